// >>> inc/dinsel_pkg.sv
// dinsel_pkg: constants, register map, field layout and carrier types
// for the discrete input and node select block.
// assumes a single 100 MHz clock domain and an apb slave with 32-bit data.
package dinsel_pkg;

  // clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEBOUNCE_NS = 2000;
  // least time, so round up to whole cycles
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // pin roles: index 0 run permit, 1 and 2 node select
  localparam int N_PINS = 3;
  localparam int PIN_RUN = 0;
  localparam int PIN_NODE_A = 1;
  localparam int PIN_NODE_B = 2;

  // register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PINCFG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_NODE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_BASE = 8'h10;

  // ctrl fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_RATE_LSB = 2;
  localparam int CTRL_ROLE_A = 4;
  localparam int CTRL_ROLE_B = 5;
  localparam int CTRL_W = 6;

  // pincfg fields: pin i side at bit 2*i, sense at bit 2*i+1
  localparam int PINCFG_W = 2 * N_PINS;

  // status fields
  localparam int ST_PERMIT = 0;
  localparam int ST_LOGIC_LSB = 1;
  localparam int ST_CAPTURED = 4;
  localparam int ST_LATE_CHG = 5;

  // node fields
  localparam int NODE_UNIT_LSB = 0;
  localparam int NODE_ADDR_LSB = 8;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0022;
  localparam logic [31:0] PINCFG_RST = 32'h0000_0000;
  localparam logic [7:0] BASE_RST = 8'h10;

  typedef enum logic {SIDE_SUPPLY, SIDE_GROUND} dinsel_side_e;
  typedef enum logic {SENSE_CLOSED, SENSE_OPEN} dinsel_sense_e;
  typedef enum logic [1:0] {SRC_UNUSED, SRC_BUS, SRC_PIN, SRC_SPARE} dinsel_src_e;
  typedef enum logic [1:0] {RATE_125K, RATE_250K, RATE_500K, RATE_1M} dinsel_rate_e;
  typedef enum logic {ROLE_UPPER, ROLE_LOWER} dinsel_role_e;

  // bus bit rates and their bit periods in clock cycles
  localparam int BITP_W = 10;
  localparam int RATE_125K_HZ = 125_000;
  localparam int RATE_250K_HZ = 250_000;
  localparam int RATE_500K_HZ = 500_000;
  localparam int RATE_1M_HZ = 1_000_000;
  localparam logic [BITP_W-1:0] BITP_125K = BITP_W'(CLK_HZ / RATE_125K_HZ);
  localparam logic [BITP_W-1:0] BITP_250K = BITP_W'(CLK_HZ / RATE_250K_HZ);
  localparam logic [BITP_W-1:0] BITP_500K = BITP_W'(CLK_HZ / RATE_500K_HZ);
  localparam logic [BITP_W-1:0] BITP_1M = BITP_W'(CLK_HZ / RATE_1M_HZ);

  // software configuration as one carrier
  typedef struct packed {
    dinsel_role_e role_b;
    dinsel_role_e role_a;
    dinsel_rate_e rate;
    dinsel_src_e run_src;
  } dinsel_ctrl_s;

  // apb request as one carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } dinsel_apb_req_s;

endpackage

// >>> design/dinsel_filter.sv
// dinsel_filter: three-flop synchroniser and debounce for one contact pin.
// assumes the pin is asynchronous to clk and bounces for less than the
// debounce time.
`timescale 1ns/100ps
module dinsel_filter #(
  parameter int unsigned DEB_CYC = dinsel_pkg::DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin,
  output logic level_r,
  output logic valid_r
);
  import dinsel_pkg::*;

  localparam int CNT_W = $clog2(DEB_CYC + 1);

  // elaboration check on the filter length
  if (DEB_CYC < 1) begin : g_bad_deb
    $error("dinsel_filter: DEB_CYC must be at least one");
  end

  logic sync1_r, sync2_r, sync3_r;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic level_nxt, valid_nxt;

  // synchroniser chain; first flop feeds only the second
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // level counts only while second and third flop agree for DEB_CYC cycles
  always_comb begin
    cnt_nxt = cnt_r;
    level_nxt = level_r;
    valid_nxt = valid_r;
    if (sync2_r != sync3_r) begin
      cnt_nxt = '0; // bounce restarts the wait
    end else if ((sync3_r != level_r) || !valid_r) begin
      if (cnt_r == CNT_W'(DEB_CYC - 1)) begin
        cnt_nxt = '0;
        level_nxt = sync3_r;
        valid_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end else begin
      cnt_nxt = '0;
    end
  end

  // filter state registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_r <= '0;
      level_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      level_r <= level_nxt;
      valid_r <= valid_nxt;
    end
  end

endmodule

// >>> design/dinsel_top.sv
// dinsel_top: discrete input conditioning, run permit gating and power-up
// node selection with bus address and bit rate choice, behind an apb slave.
// assumes contact pins are asynchronous and the bus permit and current
// command come from logic on clk.
// limitation: roles and node pin polarity only count if written before the
// one-time node capture, a few microseconds after reset.
// the late-change flag only reports; the captured unit never moves.
// the bus answers with no wait states, so pready_r is a one-cycle pulse.
//
// Notes on behaviour
// - There are exactly three contact inputs: run permit, and two node select bits.
// - The run permit input has a software set switch side and assert sense.
// - Every input defaults to supply-side wiring and assert on closed contact.
// - The logical true state is the pin level inverted once per ground side and open sense.
// - With the permit inactive the drive current command is forced to zero.
// - The permit source is unused, a bus message or the pin, the pin counting only if chosen.
// - The second and third inputs are each assignable as the upper or lower node bit.
// - Upper and lower false, false gives unit 1, false true 2, true false 3, true true 4.
// - Node select levels are captured once after power-up and later changes are ignored.
// - The bus device address follows from the captured unit number.
// - Four bus bit rates are offered: 125 kbps, 250 kbps, 500 kbps and 1 Mbps.
`timescale 1ns/100ps
module dinsel_top #(
  parameter int unsigned DEB_CYC = dinsel_pkg::DEBOUNCE_CYC,
  parameter int unsigned CUR_W = 16,
  parameter logic [7:0] BASE_ADDR_RST = dinsel_pkg::BASE_RST
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dinsel_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  input wire logic [dinsel_pkg::N_PINS-1:0] contact_pin,
  input wire logic bus_run_cmd,
  input wire logic [CUR_W-1:0] current_cmd,
  output logic [CUR_W-1:0] drive_cmd_r,
  output logic run_permit_r,
  output logic node_valid_r,
  output logic [2:0] unit_num_r,
  output logic [7:0] dev_addr_r,
  output dinsel_pkg::dinsel_rate_e bit_rate_sel_r,
  output logic [dinsel_pkg::BITP_W-1:0] bit_period_r
);
  import dinsel_pkg::*;

  // elaboration checks
  if (DEB_CYC < 1) begin : g_bad_deb
    $error("dinsel_top: DEB_CYC must be at least one");
  end
  if (CUR_W < 1 || CUR_W > 32) begin : g_bad_cur
    $error("dinsel_top: CUR_W must lie between 1 and 32");
  end

  dinsel_apb_req_s req;
  dinsel_ctrl_s ctrl_r, ctrl_nxt;
  logic [PINCFG_W-1:0] pincfg_r, pincfg_nxt;
  logic [7:0] base_r, base_nxt;
  logic late_chg_r, late_chg_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic wr_en, setup, hit;
  logic [N_PINS-1:0] level, lvalid, truth;
  logic upper, lower;
  logic captured_r, captured_nxt;
  logic cap_upper_r, cap_upper_nxt;
  logic cap_lower_r, cap_lower_nxt;
  logic [2:0] unit_nxt;
  logic [7:0] addr_nxt;
  logic permit;
  logic permit_nxt, node_valid_nxt;
  logic [CUR_W-1:0] drive_nxt;
  dinsel_rate_e rate_nxt;
  logic [BITP_W-1:0] bitp_nxt;

  // bundle the bus pins
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // per-pin filter and polarity decode
  for (genvar i = 0; i < N_PINS; i++) begin : g_pin
    dinsel_filter #(
      .DEB_CYC(DEB_CYC)
    ) i_dinsel_filter (
      .clk(clk),
      .reset_n(reset_n),
      .pin(contact_pin[i]),
      .level_r(level[i]),
      .valid_r(lvalid[i])
    );
    // supply-closed and ground-open read high as true
    assign truth[i] = level[i] ^ pincfg_r[2*i] ^ pincfg_r[2*i+1];
  end

  // bus phases: answer ready in the first access cycle, no wait states
  assign setup = req.psel && !req.penable;
  assign wr_en = req.psel && req.penable && req.pwrite && pready_r;
  assign hit = (req.paddr == OFF_CTRL) || (req.paddr == OFF_PINCFG) ||
               (req.paddr == OFF_STATUS) || (req.paddr == OFF_NODE) ||
               (req.paddr == OFF_BASE);

  // software writable configuration
  always_comb begin
    ctrl_nxt = ctrl_r;
    pincfg_nxt = pincfg_r;
    base_nxt = base_r;
    if (wr_en) begin
      unique case (req.paddr)
        OFF_CTRL: begin
          ctrl_nxt = dinsel_ctrl_s'(req.pwdata[CTRL_W-1:0]);
        end
        OFF_PINCFG: begin
          pincfg_nxt = req.pwdata[PINCFG_W-1:0];
        end
        OFF_BASE: begin
          base_nxt = req.pwdata[7:0];
        end
        default: begin
          ctrl_nxt = ctrl_r; // read-only or unmapped: write dropped
        end
      endcase
    end
  end

  // configuration registers; reset gives supply side, closed sense
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_r <= dinsel_ctrl_s'(CTRL_RST[CTRL_W-1:0]);
      pincfg_r <= PINCFG_RST[PINCFG_W-1:0];
      base_r <= BASE_ADDR_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      pincfg_r <= pincfg_nxt;
      base_r <= base_nxt;
    end
  end

  // read data and answer, prepared in the setup cycle
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup) begin
      pready_nxt = 1'b1;
      pslverr_nxt = !hit;
      if (!req.pwrite) begin
        unique case (req.paddr)
          OFF_CTRL: begin
            prdata_nxt[CTRL_W-1:0] = ctrl_r;
          end
          OFF_PINCFG: begin
            prdata_nxt[PINCFG_W-1:0] = pincfg_r;
          end
          OFF_STATUS: begin
            prdata_nxt[ST_PERMIT] = run_permit_r;
            prdata_nxt[ST_LOGIC_LSB +: N_PINS] = truth;
            prdata_nxt[ST_CAPTURED] = captured_r;
            prdata_nxt[ST_LATE_CHG] = late_chg_r;
          end
          OFF_NODE: begin
            prdata_nxt[NODE_UNIT_LSB +: 3] = unit_num_r;
            prdata_nxt[NODE_ADDR_LSB +: 8] = dev_addr_r;
          end
          OFF_BASE: begin
            prdata_nxt[7:0] = base_r;
          end
          default: begin
            prdata_nxt = 32'h0000_0000; // unmapped reads zero with error
          end
        endcase
      end
    end
  end

  // bus answer registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // role steering; pin a wins upper and pin b wins lower if both share a role
  // a bit that neither pin claims reads false
  always_comb begin
    upper = 1'b0;
    lower = 1'b0;
    if (ctrl_r.role_a == ROLE_UPPER) begin
      upper = truth[PIN_NODE_A];
    end else if (ctrl_r.role_b == ROLE_UPPER) begin
      upper = truth[PIN_NODE_B];
    end
    if (ctrl_r.role_b == ROLE_LOWER) begin
      lower = truth[PIN_NODE_B];
    end else if (ctrl_r.role_a == ROLE_LOWER) begin
      lower = truth[PIN_NODE_A];
    end
  end

  // one-shot capture once both node pins have settled after reset
  // filters start invalid, so a reset level is never taken as a setting
  always_comb begin
    captured_nxt = captured_r;
    cap_upper_nxt = cap_upper_r;
    cap_lower_nxt = cap_lower_r;
    late_chg_nxt = late_chg_r;
    if (!captured_r) begin
      if (lvalid[PIN_NODE_A] && lvalid[PIN_NODE_B]) begin
        captured_nxt = 1'b1;
        cap_upper_nxt = upper;
        cap_lower_nxt = lower;
      end
    end else begin
      // write one clears the late-change flag; a standing difference from the captured bits wins
      if (wr_en && (req.paddr == OFF_STATUS) && req.pwdata[ST_LATE_CHG]) begin
        late_chg_nxt = 1'b0;
      end
      if ((upper != cap_upper_r) || (lower != cap_lower_r)) begin
        late_chg_nxt = 1'b1;
      end
    end
  end

  // unit number and device address from the captured bits
  // two captured bits plus one never carry out of three bits
  always_comb begin
    unit_nxt = {1'b0, cap_upper_r, cap_lower_r} + 3'h1;
    addr_nxt = base_r + {6'h00, cap_upper_r, cap_lower_r};
    if (!captured_r) begin
      unit_nxt = 3'h0; // no unit until the capture
      addr_nxt = 8'h00;
    end
  end

  // capture and node registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      captured_r <= 1'b0;
      cap_upper_r <= 1'b0;
      cap_lower_r <= 1'b0;
      late_chg_r <= 1'b0;
      unit_num_r <= 3'h0;
      dev_addr_r <= 8'h00;
      node_valid_r <= 1'b0;
    end else begin
      captured_r <= captured_nxt;
      cap_upper_r <= cap_upper_nxt;
      cap_lower_r <= cap_lower_nxt;
      late_chg_r <= late_chg_nxt;
      unit_num_r <= unit_nxt;
      dev_addr_r <= addr_nxt;
      node_valid_r <= node_valid_nxt;
    end
  end

  assign node_valid_nxt = captured_r;

  // permit source select; an unsettled pin holds the actuator off
  // the bus command is on clk already, so only the pin is filtered
  always_comb begin
    unique case (ctrl_r.run_src)
      SRC_UNUSED: permit = 1'b1;
      SRC_BUS: permit = bus_run_cmd;
      SRC_PIN: permit = lvalid[PIN_RUN] && truth[PIN_RUN];
      default: permit = 1'b0; // spare code is treated as off, the safe side
    endcase
  end

  // gated drive command; limp actuator saves power when not permitted
  // zero, not a held value, so a lost permit never leaves current flowing
  always_comb begin
    permit_nxt = permit;
    drive_nxt = permit ? current_cmd : '0;
  end

  // bit rate selection and its bit period
  // every rate code is legal, hence no default
  always_comb begin
    rate_nxt = ctrl_r.rate;
    unique case (ctrl_r.rate)
      RATE_125K: bitp_nxt = BITP_125K;
      RATE_250K: bitp_nxt = BITP_250K;
      RATE_500K: bitp_nxt = BITP_500K;
      RATE_1M: bitp_nxt = BITP_1M;
    endcase
  end

  // permit, drive and rate registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run_permit_r <= 1'b0;
      drive_cmd_r <= '0;
      bit_rate_sel_r <= RATE_125K;
      bit_period_r <= BITP_125K;
    end else begin
      run_permit_r <= permit_nxt;
      drive_cmd_r <= drive_nxt;
      bit_rate_sel_r <= rate_nxt;
      bit_period_r <= bitp_nxt;
    end
  end

endmodule

// >>> verification/dinsel_harness.sv
// dinsel_harness: wired contact states of the harness, with chatter
// on the run contact. assumes levels are set before reset is released.
`timescale 1ns/100ps
module dinsel_harness (
  input wire logic clk,
  input wire logic [2:0] wired,
  input wire logic bounce,
  output logic [2:0] contact_pin
);
  logic chatter_r = 1'b0;
  // flips every cycle, far faster than any debounce window
  always_ff @(posedge clk) begin
    chatter_r <= ~chatter_r;
  end
  // fixed levels, valid from before power-up
  assign contact_pin = {wired[2:1], wired[0] ^ (bounce & chatter_r)};
endmodule

// >>> verification/dinsel_checker.sv
// dinsel_checker: port assertions for dinsel_top.
// assumes one clock and a synchronous active low reset.
`timescale 1ns/100ps
module dinsel_checker #(
  parameter int unsigned CUR_W = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata_r,
  input wire logic pready_r,
  input wire logic pslverr_r,
  input wire logic [CUR_W-1:0] current_cmd,
  input wire logic [CUR_W-1:0] drive_cmd_r,
  input wire logic run_permit_r,
  input wire logic node_valid_r,
  input wire logic [2:0] unit_num_r,
  input wire dinsel_pkg::dinsel_rate_e bit_rate_sel_r,
  input wire logic [dinsel_pkg::BITP_W-1:0] bit_period_r
);
  import dinsel_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // bus answer: one cycle after setup, one cycle long
  a_ready_after_setup: assert property (psel && !penable |=> pready_r)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready_r |=> !pready_r)
    else $error("ready held too long");
  a_error_no_data: assert property (pslverr_r |-> pready_r && prdata_r == 0)
    else $error("error without ready or with data");
  // current only passes while permitted, zero otherwise
  a_drive_gated: assert property (drive_cmd_r == (run_permit_r ? $past(current_cmd) : '0))
    else $error("drive not gated by permit");
  // node number range, before and after capture
  a_unit_range: assert property (node_valid_r |-> unit_num_r inside {[1:4]})
    else $error("unit out of range");
  a_unit_zero: assert property (!node_valid_r |-> unit_num_r == 0)
    else $error("unit before capture");
  a_unit_held: assert property (node_valid_r && $past(node_valid_r) |-> $stable(unit_num_r))
    else $error("unit changed after capture");
  a_valid_sticky: assert property (node_valid_r |=> node_valid_r)
    else $error("capture lost");
  a_rate_period: assert property (bit_period_r == (10'h320 >> bit_rate_sel_r))
    else $error("bit period wrong");
  c_unit4: cover property (node_valid_r && unit_num_r == 4);
  c_slverr: cover property (pslverr_r);
  c_permit: cover property ($rose(run_permit_r));
endmodule
bind dinsel_top dinsel_checker #(.CUR_W(CUR_W)) i_dinsel_checker (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
  .current_cmd(current_cmd), .drive_cmd_r(drive_cmd_r),
  .run_permit_r(run_permit_r), .node_valid_r(node_valid_r),
  .unit_num_r(unit_num_r), .bit_rate_sel_r(bit_rate_sel_r),
  .bit_period_r(bit_period_r)
);

// >>> verification/tb_dinsel_top.sv
// tb_dinsel_top: self-checking bench for dinsel_top over apb and contacts.
// assumes the harness model and a short debounce count.
`timescale 1ns/100ps
module tb_dinsel_top;
  import dinsel_pkg::*;
  localparam int DEB = 8;
  logic clk = 0;
  logic reset_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic bus_run_cmd = 0;
  logic bounce = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata_r, rq;
  logic pready_r, pslverr_r, re, run_permit_r, node_valid_r;
  logic [2:0] wired = '0;
  logic [2:0] contact_pin, unit_num_r;
  logic [15:0] current_cmd = '0;
  logic [15:0] drive_cmd_r;
  logic [7:0] dev_addr_r;
  dinsel_rate_e bit_rate_sel_r;
  logic [BITP_W-1:0] bit_period_r;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  dinsel_top #(.DEB_CYC(DEB)) i_dinsel_top (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .contact_pin(contact_pin),
    .bus_run_cmd(bus_run_cmd), .current_cmd(current_cmd),
    .drive_cmd_r(drive_cmd_r), .run_permit_r(run_permit_r),
    .node_valid_r(node_valid_r), .unit_num_r(unit_num_r),
    .dev_addr_r(dev_addr_r), .bit_rate_sel_r(bit_rate_sel_r),
    .bit_period_r(bit_period_r)
  );
  dinsel_harness i_dinsel_harness (
    .clk(clk), .wired(wired), .bounce(bounce), .contact_pin(contact_pin)
  );
  // clock and hang guard
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // one apb transfer, entered just after a rising edge; returns one edge
  // after the access so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready_r !== 1'b1);
    rq = prdata_r;
    re = pslverr_r;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // power-up with the harness already wired
  task automatic rst(input logic [2:0] lv);
    wired <= lv;
    reset_n <= 0;
    repeat (5) @(posedge clk);
    reset_n <= 1;
    @(posedge clk);
  endtask
  task automatic node_wait();
    for (int n = 0; n < 100 && node_valid_r !== 1'b1; n++) @(posedge clk);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_regs();
    rst(3'b001);
    apb(0, OFF_CTRL, '0);
    chk(rq, CTRL_RST);
    apb(0, OFF_PINCFG, '0);
    chk(rq, PINCFG_RST);
    apb(0, OFF_BASE, '0);
    chk(rq, 32'h0000_0010);
    apb(0, 8'h14, '0);
    chk(32'(re), 32'h0000_0001);
    chk(rq, 32'h0000_0000);
    apb(1, OFF_BASE, 32'h0000_0040);
    node_wait();
    chk(32'(dev_addr_r), 32'h0000_0040);
    @(posedge clk);
    $display("t_regs done");
  endtask
  task automatic t_units();
    for (int u = 0; u < 4; u++) begin
      rst({u[0], u[1], 1'b1});
      node_wait();
      chk(32'(unit_num_r), 32'(u + 1));
      @(posedge clk);
      apb(0, OFF_NODE, '0);
      chk(rq, 32'(((16 + u) << 8) | (u + 1)));
    end
    $display("t_units done");
  endtask
  task automatic t_roles();
    rst(3'b101);
    apb(1, OFF_CTRL, 32'h0000_0012);
    node_wait();
    chk(32'(unit_num_r), 32'h0000_0003);
    @(posedge clk);
    $display("t_roles done");
  endtask
  task automatic t_late();
    rst(3'b001);
    node_wait();
    wired <= 3'b111;
    repeat (DEB + 10) @(posedge clk);
    chk(32'(unit_num_r), 32'h0000_0001);
    apb(0, OFF_STATUS, '0);
    chk(32'(rq[5:1]), 32'h0000_001F);
    // a clear while the pins still differ loses to the set
    apb(1, OFF_STATUS, 32'h0000_0020);
    apb(0, OFF_STATUS, '0);
    chk(32'(rq[5]), 32'h0000_0001);
    wired <= 3'b001;
    repeat (DEB + 10) @(posedge clk);
    apb(1, OFF_STATUS, 32'h0000_0020);
    apb(0, OFF_STATUS, '0);
    chk(32'(rq[5]), 32'h0000_0000);
    $display("t_late done");
  endtask
  // every side, sense and level of the run contact
  task automatic t_decode();
    logic [2:0] v;
    rst(3'b001);
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      apb(1, OFF_PINCFG, 32'(v[1:0]));
      wired <= {2'b00, v[2]};
      repeat (DEB + 8) @(posedge clk);
      apb(0, OFF_STATUS, '0);
      chk(32'(rq[1:0]), {30'h0000_0000, {2{^v}}});
    end
    $display("t_decode done");
  endtask
  // every permit source, bus command low and high
  task automatic t_src();
    logic [1:0] s;
    logic e;
    rst(3'b001);
    node_wait();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      s = 2'(i >> 1);
      e = (s == 0) || (s == 1 && i[0]) || (s == 2);
      bus_run_cmd <= i[0];
      current_cmd <= 16'h1000 + 16'(i);
      apb(1, OFF_CTRL, 32'h0000_0020 | 32'(s));
      repeat (3) @(posedge clk);
      #1;
      chk(32'(run_permit_r), 32'(e));
      chk(32'(drive_cmd_r), e ? 32'(current_cmd) : '0);
    end
    $display("t_src done");
  endtask
  task automatic t_rate();
    @(posedge clk);
    for (int r = 0; r < 4; r++) begin
      apb(1, OFF_CTRL, 32'h0000_0022 | 32'(r << 2));
      #1;
      chk(32'(bit_rate_sel_r), 32'(r));
      chk(32'(bit_period_r), 32'h0000_0320 >> r);
      @(posedge clk);
    end
    $display("t_rate done");
  endtask
  // chatter must not move the permit; a settled open must drop it
  task automatic t_bounce();
    rst(3'b001);
    node_wait();
    bounce <= 1;
    wired <= 3'b000;
    repeat (60) @(posedge clk);
    #1;
    chk(32'(run_permit_r), 32'h0000_0001);
    bounce <= 0;
    repeat (DEB + 8) @(posedge clk);
    #1;
    chk(32'(run_permit_r), 32'h0000_0000);
    $display("t_bounce done");
  endtask
  initial begin
    t_regs();
    t_units();
    t_roles();
    t_late();
    t_decode();
    t_src();
    t_rate();
    t_bounce();
    test_done();
  end
endmodule
